// file: trap_halt_and_watchdog_control.sv
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module trap_halt_and_watchdog_control (
  input wire logic clk, // 10 MHz cpu clock
  input wire logic reset, // synchronous, active high
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [3:0] op_class, // decoded control op
  input wire logic op_valid, // op executes this cycle
  input wire logic instr_retire, // instruction completed
  input wire logic privileged, // privileged state
  input wire logic legacy_status_word, // legacy mode
  input wire logic ext_blocked, // external irqs blocked
  input wire logic high_irq_active, // high level irq active
  input wire trap_pkg::fault_s fault, // fault reports
  input wire trap_pkg::ctx_s ctx, // sequencing context
  input wire logic [31:0] status_first_word, // current word 1
  input wire logic [31:0] status_second_word, // current word 2
  input wire logic [31:0] device_table_entry, // current entry
  input wire logic [31:0] device_irq_entry, // current entry
  input wire logic [23:0] trap_vector_addr, // vector of trap
  input wire logic [23:0] ctx_block_addr, // context block base
  input wire logic mem_ready, // memory accepts store
  output logic trap_take, // vector the trap (pulse)
  output trap_pkg::trap_code_e trap_code, // last trap raised, registered
  output logic [31:0] cpu_status_word, // cause descriptor
  output logic cpu_halted, // cpu stopped
  output logic irq_active_light, // panel indicator
  output logic [31:0] halt_first_word, // word 1 after halt
  output logic mem_wr, // store request
  output logic [23:0] mem_addr, // store address
  output logic [31:0] mem_wdata, // store data
  output logic irq // level interrupt
);

  ////////////////////////////////////////////////////////////////
  logic [2:0] ctrl; // control register
  logic [3:0] irq_stat; // sticky events
  logic [3:0] irq_mask; // event enables
  logic restart_pulse; // software restart
  logic [7:0] wdog_cnt; // blocked instruction count
  trap_pkg::halt_st_e state; // halt sequencer
  logic [2:0] save_idx; // error word index
  logic [3:0] events; // event pulses
  logic trap_raise; // any trap this cycle
  trap_pkg::trap_code_e next_code; // trap chosen
  logic halt_req; // trap-halt condition
  logic arming; // trap arms halt logic
  logic ctx_store; // context word five store pending
  logic [23:0] ctx_addr; // latched context address
  logic wdog_trip; // watchdog over limit
  logic restart_seen; // restart since last cycle

  wire bus_wr = avs_write && !avs_waitrequest;
  wire trap_en = ctrl[trap_pkg::ctrl_trap_en_bit];

  ////////////////////////////////////////////////////////////////
  // zero-wait slave
  assign avs_waitrequest = 1'b0;

  // read mux, unmapped reads zero
  always_comb begin
    avs_readdata = 32'h00000000;
    case (avs_address)
      trap_pkg::ctrl_off: avs_readdata = {29'h0, ctrl};
      trap_pkg::status_off: avs_readdata = {30'h0, irq_active_light,
                                            cpu_halted};
      trap_pkg::irq_stat_off: avs_readdata = {28'h0, irq_stat};
      trap_pkg::irq_mask_off: avs_readdata = {28'h0, irq_mask};
      default: avs_readdata = 32'h00000000;
    endcase
  end

  // control register, restart bit self clears
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= trap_pkg::ctrl_reset;
    end else if (bus_wr && avs_address == trap_pkg::ctrl_off) begin
      ctrl <= avs_writedata[2:0] & 3'h6;
    end
  end
  assign restart_pulse = bus_wr && avs_address == trap_pkg::ctrl_off &&
                         avs_writedata[trap_pkg::ctrl_restart_bit];

  // mask register
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask <= 4'h0;
    end else if (bus_wr && avs_address == trap_pkg::irq_mask_off) begin
      irq_mask <= avs_writedata[3:0];
    end
  end

  // sticky status: set wins over write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat <= 4'h0;
    end else if (bus_wr && avs_address == trap_pkg::irq_stat_off) begin
      irq_stat <= (irq_stat & ~avs_writedata[3:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end
  // events: trap raised, halt entered, watchdog, system check
  assign events = {fault.sys_check, wdog_trip, halt_req, trap_raise};
  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////
  // trap selection, priority order top first
  always_comb begin
    next_code = trap_pkg::trap_none;
    // both modes: the legacy halt on a protocol fault needs a trap code
    if (ctx.irq_seq && (fault.parity || fault.nonpresent ||
        fault.protocol)) begin
      next_code = trap_pkg::trap_machine_check;
    end else if (fault.parity) begin
      next_code = trap_pkg::trap_parity;
    end else if (fault.nonpresent) begin
      next_code = trap_pkg::trap_nonpresent;
    end else if (fault.map_fault) begin
      next_code = trap_pkg::trap_map_fault;
    end else if (fault.sys_check) begin
      next_code = trap_pkg::trap_system_check;
    end else if (op_valid && legacy_status_word &&
        (op_class == trap_pkg::block_external_irq_op ||
         op_class == trap_pkg::unblock_external_irq_op ||
         op_class == trap_pkg::load_status_dword_op ||
         op_class == trap_pkg::enable_arith_trap_op ||
         op_class == trap_pkg::disable_arith_trap_op ||
         op_class == trap_pkg::supervisor_call_op)) begin
      next_code = trap_pkg::trap_undefined;
    end else if (op_valid && !privileged && op_class != trap_pkg::op_none
        && op_class != trap_pkg::supervisor_call_op
        && op_class != trap_pkg::wait_op) begin
      next_code = trap_pkg::trap_privilege;
    end else if (op_valid && op_class == trap_pkg::wait_op &&
        ext_blocked) begin
      next_code = trap_pkg::trap_block_timeout;
    end else if (wdog_trip) begin
      next_code = trap_pkg::trap_block_timeout;
    end else if (op_valid && op_class == trap_pkg::supervisor_call_op) begin
      next_code = trap_pkg::trap_supervisor;
    end else if (fault.arith) begin
      next_code = trap_pkg::trap_arith;
    end else if (fault.call_monitor) begin
      next_code = trap_pkg::trap_call_monitor;
    end
  end
  // blocking and high-level irqs do not gate traps
  assign trap_raise = state == trap_pkg::st_run &&
                      next_code != trap_pkg::trap_none;

  // halt-arming set
  always_comb begin
    case (next_code)
      trap_pkg::trap_parity, trap_pkg::trap_nonpresent,
      trap_pkg::trap_undefined, trap_pkg::trap_privilege,
      trap_pkg::trap_machine_check, trap_pkg::trap_system_check,
      trap_pkg::trap_map_fault: arming = 1'b1;
      default: arming = 1'b0;
    endcase
  end

  // halt decision per mode
  always_comb begin
    if (legacy_status_word) begin
      halt_req = trap_raise && ctx.irq_seq &&
                 ((ctx.dedicated_loc && (fault.parity ||
                   fault.nonpresent)) ||
                  fault.protocol);
    end else begin
      halt_req = trap_raise && arming && !trap_en;
    end
  end

  // vector a trap unless it halts
  assign trap_take = trap_raise && !halt_req;

  ////////////////////////////////////////////////////////////////
  // blocked-instruction watchdog
  always_ff @(posedge clk) begin
    if (reset || !ext_blocked || trap_raise) begin
      wdog_cnt <= 8'h00;
    end else if (instr_retire && ctrl[trap_pkg::ctrl_wdog_en_bit] &&
                 wdog_cnt <= trap_pkg::wdog_limit) begin
      wdog_cnt <= wdog_cnt + 8'h01;
    end
  end
  assign wdog_trip = wdog_cnt > trap_pkg::wdog_limit;

  ////////////////////////////////////////////////////////////////
  // trap code and status word capture
  always_ff @(posedge clk) begin
    if (reset) begin
      trap_code <= trap_pkg::trap_none;
      cpu_status_word <= 32'h00000000;
      ctx_addr <= 24'h000000;
    end else if (trap_raise) begin
      trap_code <= next_code;
      cpu_status_word <= {20'h0, fault.sys_cause, 4'h0,
                          next_code};
      ctx_addr <= ctx_block_addr + 24'h000010;
    end
  end

  // halt sequencer: save error words then hold
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= trap_pkg::st_run;
      save_idx <= 3'h0;
      halt_first_word <= 32'h00000000;
    end else begin
      case (state)
        trap_pkg::st_run: begin
          save_idx <= legacy_status_word ? 3'h0 : 3'h0;
          if (halt_req) begin
            state <= trap_pkg::st_save;
            // low 24 bits get the trap vector, halfword bit included; top byte kept
            halt_first_word <= {status_first_word[31:24],
                                trap_vector_addr};
          end
        end
        trap_pkg::st_save: begin
          if (mem_ready) begin
            // skip word two in legacy mode
            if (save_idx == 3'h0 && legacy_status_word) begin
              save_idx <= 3'h2;
            end else if (save_idx == 3'h4) begin
              state <= trap_pkg::st_halt;
            end else begin
              save_idx <= save_idx + 3'h1;
            end
          end
        end
        trap_pkg::st_halt: begin
          if (restart_pulse) begin
            state <= trap_pkg::st_run;
          end
        end
        default: state <= trap_pkg::st_run;
      endcase
    end
  end

  // context word five store after vectored trap, non-legacy mode only
  always_ff @(posedge clk) begin
    if (reset) begin
      ctx_store <= 1'b0;
    end else if (trap_take && !legacy_status_word) begin
      ctx_store <= 1'b1;
    end else if (mem_ready && state == trap_pkg::st_run) begin
      ctx_store <= 1'b0;
    end
  end

  // restart edge marker for assertions
  always_ff @(posedge clk) begin
    if (reset) begin
      restart_seen <= 1'b0;
    end else begin
      restart_seen <= restart_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////
  // store port
  always_comb begin
    mem_wr = 1'b0;
    mem_addr = 24'h000000;
    mem_wdata = 32'h00000000;
    if (state == trap_pkg::st_save) begin
      mem_wr = 1'b1;
      mem_addr = trap_pkg::err_base_addr +
                 24'(save_idx) * trap_pkg::word_step;
      case (save_idx)
        3'h0: mem_wdata = halt_first_word;
        3'h1: mem_wdata = status_second_word;
        3'h2: mem_wdata = cpu_status_word;
        3'h3: mem_wdata = device_table_entry;
        default: mem_wdata = device_irq_entry;
      endcase
    end else if (ctx_store) begin
      mem_wr = 1'b1;
      mem_addr = ctx_addr;
      mem_wdata = cpu_status_word;
    end
  end

  // halt and panel light
  assign cpu_halted = state != trap_pkg::st_run;
  assign irq_active_light = cpu_halted;

  ////////////////////////////////////////////////////////////////
  // checks
  a_priv_check: assert property (@(posedge clk) disable iff (reset)
    (trap_raise && op_valid && !privileged && !legacy_status_word &&
     op_class == trap_pkg::block_external_irq_op &&
     fault == '0 && !wdog_trip) |->
     next_code == trap_pkg::trap_privilege)
    else $error("unprivileged op not trapped");
  a_legacy_undef: assert property (@(posedge clk) disable iff (reset)
    (op_valid && legacy_status_word && state == trap_pkg::st_run &&
     op_class == trap_pkg::supervisor_call_op && fault == '0) |->
     trap_take && next_code == trap_pkg::trap_undefined)
    else $error("legacy op not undefined");
  a_blocked_trap: assert property (@(posedge clk) disable iff (reset)
    (state == trap_pkg::st_run && ext_blocked && fault.map_fault &&
     !fault.parity && !fault.nonpresent) |-> trap_raise)
    else $error("trap lost while blocked");
  a_halt_gate: assert property (@(posedge clk) disable iff (reset)
    (trap_raise && !legacy_status_word) |->
     halt_req == (arming && !trap_en))
    else $error("halt gate wrong");
  a_no_arm: assert property (@(posedge clk) disable iff (reset)
    (trap_raise && (next_code == trap_pkg::trap_supervisor ||
     next_code == trap_pkg::trap_arith)) |-> !halt_req)
    else $error("non-arming trap halted");
  a_wait_block: assert property (@(posedge clk) disable iff (reset)
    (state == trap_pkg::st_run && op_valid && ext_blocked &&
     op_class == trap_pkg::wait_op && privileged && fault == '0) |->
     trap_raise)
    else $error("wait while blocked not trapped");
  a_wdog_limit: assert property (@(posedge clk) disable iff (reset)
    wdog_cnt <= 8'h81)
    else $error("watchdog overran");
  a_halt_light: assert property (@(posedge clk) disable iff (reset)
    halt_req |=> cpu_halted && irq_active_light && mem_wr &&
     mem_addr == trap_pkg::err_base_addr)
    else $error("halt did not start save");
  a_halt_hold: assert property (@(posedge clk) disable iff (reset)
    (state == trap_pkg::st_halt && !restart_seen && !restart_pulse) |=>
     state == trap_pkg::st_halt && !mem_wr)
    else $error("halt released early");

  ////////////////////////////////////////////////////////////////
  // extra checks: high levels, restart, save order, context store
  a_high_level: assert property (@(posedge clk) disable iff (reset)
    (state == trap_pkg::st_run && high_irq_active && fault.map_fault &&
     !fault.parity && !fault.nonpresent) |-> trap_raise)
    else $error("trap lost under high level irq");
  // restart leaves the halt on the next edge
  a_restart_run: assert property (@(posedge clk) disable iff (reset)
    (state == trap_pkg::st_halt && restart_pulse) |=>
     state == trap_pkg::st_run)
    else $error("restart did not resume");
  // legacy save skips the second status word
  a_legacy_skip: assert property (@(posedge clk) disable iff (reset)
    (state == trap_pkg::st_save && save_idx == 3'h0 && mem_ready &&
     legacy_status_word) |=> save_idx == 3'h2)
    else $error("legacy save did not skip word two");
  // vectored trap outside legacy mode stores the status word to context word five
  a_ctx_store: assert property (@(posedge clk) disable iff (reset)
    (trap_take && !legacy_status_word) |=>
     mem_wr && mem_addr == ctx_addr)
    else $error("context store missing");

endmodule : trap_halt_and_watchdog_control

// file: trap_pkg.sv
package trap_pkg;

  // avalon register byte offsets
  localparam logic [3:0] ctrl_off = 4'h0;      // control
  localparam logic [3:0] status_off = 4'h4;    // cpu state
  localparam logic [3:0] irq_stat_off = 4'h8;  // sticky events
  localparam logic [3:0] irq_mask_off = 4'hC;  // event mask

  // control field positions
  localparam int ctrl_restart_bit = 0;   // write one: leave halt
  localparam int ctrl_trap_en_bit = 1;   // traps enabled
  localparam int ctrl_wdog_en_bit = 2;   // watchdog enabled
  localparam logic [2:0] ctrl_reset = 3'h0;

  // error save area
  localparam logic [23:0] err_base_addr = 24'h000530;
  localparam logic [23:0] err_cpusw_addr = 24'h000538;
  localparam logic [23:0] err_irqent_addr = 24'h000540;
  localparam logic [23:0] word_step = 24'h000004;

  // watchdog limit
  localparam logic [7:0] wdog_limit = 8'h80;

  // first status word: halfword indicator position
  localparam int halfword_bit = 5;

  // trap codes
  typedef enum logic [3:0] {
    trap_none = 4'h0,
    trap_parity = 4'h1,
    trap_nonpresent = 4'h2,
    trap_undefined = 4'h3,
    trap_privilege = 4'h4,
    trap_machine_check = 4'h5,
    trap_system_check = 4'h6,
    trap_map_fault = 4'h7,
    trap_supervisor = 4'h8,
    trap_arith = 4'h9,
    trap_call_monitor = 4'hA,
    trap_block_timeout = 4'hB
  } trap_code_e;

  // control-instruction classes from decoder
  typedef enum logic [3:0] {
    op_none = 4'h0,
    block_external_irq_op = 4'h1,
    unblock_external_irq_op = 4'h2,
    load_status_dword_op = 4'h3,
    load_status_dword_remap_op = 4'h4,
    set_cpu_mode_op = 4'h5,
    supervisor_call_op = 4'h6,
    enable_arith_trap_op = 4'h7,
    disable_arith_trap_op = 4'h8,
    wait_op = 4'h9
  } ctl_op_e;

  // fault reports
  typedef struct packed {
    logic parity;       // memory parity error
    logic nonpresent;   // nonpresent memory
    logic protocol;     // bus protocol violation
    logic map_fault;    // map fault
    logic sys_check;    // illogical sequence
    logic arith;        // arithmetic exception
    logic call_monitor; // call monitor interrupt
    logic [3:0] sys_cause; // system check cause
  } fault_s;

  // context flags from sequencer
  typedef struct packed {
    logic irq_seq;       // interrupt or context switch
    logic dedicated_loc; // store-place-branch / reset-irq seq
  } ctx_s;

  // halt save sequencer
  typedef enum logic [4:0] {
    st_run = 5'b00001,
    st_save = 5'b00010,
    st_halt = 5'b00100,
    st_r3 = 5'b01000,
    st_r4 = 5'b10000
  } halt_st_e;

endpackage : trap_pkg

// file: test_trap_halt_and_watchdog_control.sv
`timescale 1ns/1ps
module test_trap_halt_and_watchdog_control;
  ////////////////////////////////////////////////////////////
  logic clk = 1'b0; // 10 MHz cpu clock
  logic reset = 1'b1; // sync reset
  logic [3:0] avs_address = 4'h0; // bus address
  logic avs_read = 1'b0; // bus read
  logic avs_write = 1'b0; // bus write
  logic [31:0] avs_writedata = 32'h0; // bus write data
  logic [31:0] avs_readdata; // bus read data
  logic avs_waitrequest; // bus stall
  logic [3:0] op_class = 4'h0; // control op
  logic op_valid = 1'b0; // op strobe
  logic instr_retire = 1'b0; // retire strobe
  logic privileged = 1'b1; // privilege level
  logic legacy_status_word = 1'b0; // legacy mode
  logic ext_blocked = 1'b0; // irqs blocked
  logic high_irq_active = 1'b0; // high level busy
  trap_pkg::fault_s fault = '0; // fault pulses
  trap_pkg::ctx_s ctx = '0; // sequence context
  logic [31:0] status_first_word = 32'hA5A55A20; // bit 5 set
  logic [31:0] status_second_word = 32'h12345678; // word 2
  logic [31:0] device_table_entry = 32'hDEAD0001; // table entry
  logic [31:0] device_irq_entry = 32'hBEEF0002; // irq entry
  logic [23:0] trap_vector_addr = 24'h0000F0; // trap vector
  logic [23:0] ctx_block_addr = 24'h000700; // context block
  logic mem_ready = 1'b1; // store accept
  logic trap_take, cpu_halted, irq_active_light, mem_wr, irq; // flags
  trap_pkg::trap_code_e trap_code; // last trap
  logic [31:0] cpu_status_word, halt_first_word, mem_wdata; // words
  logic [23:0] mem_addr; // store address
  int err_total = 0; // mismatches
  int compares = 0; // comparisons
  int takes = 0; // trap pulses seen
  int n, t0; // scratch counters
  logic [24:0] r; // current row
  // row: op, priv leg blk hi seq, fault, take, code
  logic [24:0] rows [26] = '{
    {4'h1, 5'b00000, 11'h000, 1'b1, 4'h4}, {4'h2, 5'b00000, 11'h000, 1'b1, 4'h4},
    {4'h3, 5'b00000, 11'h000, 1'b1, 4'h4}, {4'h4, 5'b00000, 11'h000, 1'b1, 4'h4},
    {4'h5, 5'b00000, 11'h000, 1'b1, 4'h4}, {4'h7, 5'b00000, 11'h000, 1'b1, 4'h4},
    {4'h8, 5'b00000, 11'h000, 1'b1, 4'h4}, {4'h1, 5'b11000, 11'h000, 1'b1, 4'h3},
    {4'h2, 5'b11000, 11'h000, 1'b1, 4'h3}, {4'h3, 5'b11000, 11'h000, 1'b1, 4'h3},
    {4'h7, 5'b11000, 11'h000, 1'b1, 4'h3}, {4'h8, 5'b11000, 11'h000, 1'b1, 4'h3},
    {4'h6, 5'b11000, 11'h000, 1'b1, 4'h3}, {4'h5, 5'b11000, 11'h000, 1'b0, 4'h0},
    {4'h4, 5'b11000, 11'h000, 1'b0, 4'h0}, {4'h1, 5'b10000, 11'h000, 1'b0, 4'h0},
    {4'h9, 5'b10100, 11'h000, 1'b1, 4'hB}, {4'h9, 5'b10000, 11'h000, 1'b0, 4'h0},
    {4'h0, 5'b10000, 11'h400, 1'b1, 4'h1}, {4'h0, 5'b10000, 11'h200, 1'b1, 4'h2},
    {4'h0, 5'b10110, 11'h080, 1'b1, 4'h7}, {4'h0, 5'b10000, 11'h045, 1'b1, 4'h6},
    {4'h0, 5'b10000, 11'h020, 1'b1, 4'h9}, {4'h0, 5'b10000, 11'h010, 1'b1, 4'hA},
    {4'h0, 5'b10001, 11'h400, 1'b1, 4'h5}, {4'h0, 5'b10001, 11'h100, 1'b1, 4'h5}};

  trap_halt_and_watchdog_control dut (.clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .op_class,
    .op_valid, .instr_retire, .privileged, .legacy_status_word, .ext_blocked,
    .high_irq_active, .fault, .ctx, .status_first_word, .status_second_word,
    .device_table_entry, .device_irq_entry, .trap_vector_addr, .ctx_block_addr,
    .mem_ready, .trap_take, .trap_code, .cpu_status_word, .cpu_halted,
    .irq_active_light, .halt_first_word, .mem_wr, .mem_addr, .mem_wdata, .irq);

  // clock and trap pulse counter
  always #50 clk = ~clk;
  always @(negedge clk) if (trap_take === 1'b1) takes <= takes + 1;

  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic finish_test;
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    if (k >= 50) err_total++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // masked read compare
  task automatic rd(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask : rd

  // halt with traps off: collect stores under stalls, then poke it
  task automatic hrun(input logic leg, input logic [10:0] f, input int nw);
    logic [23:0] ga [6];
    logic [31:0] gd [6];
    logic [31:0] ev [5];
    int c, j;
    c = 0;
    ev = '{32'h0, status_second_word, 32'h1, device_table_entry,
           device_irq_entry};
    @(posedge clk);
    legacy_status_word <= leg;
    ctx <= {leg, leg};
    fault <= f;
    mem_ready <= 1'b0;
    @(posedge clk);
    fault <= '0;
    repeat (30) begin
      @(posedge clk);
      mem_ready <= ~mem_ready;
      @(negedge clk);
      if (mem_wr === 1'b1 && mem_ready === 1'b1 && c < 6) begin
        ga[c] = mem_addr;
        gd[c] = mem_wdata;
        c++;
      end
    end
    check(32'(c), 32'(nw));
    for (int k = 0; k < nw && k < c; k++) begin
      j = (leg && k > 0) ? k + 1 : k;
      check({8'h0, ga[k]}, {8'h0, trap_pkg::err_base_addr
            + 24'(j) * trap_pkg::word_step});
      if (j == 0) check(gd[k] & 32'h00FFFFDF, {8'h0, trap_vector_addr}
                        & 32'h00FFFFDF);
      else if (j != 2 || !leg) check(gd[k], ev[j]);
    end
    check({30'h0, cpu_halted, irq_active_light}, 32'h3);
    check(halt_first_word & 32'h00FFFFDF, {8'h0, trap_vector_addr}
          & 32'h00FFFFDF);
    c = 0;
    @(posedge clk);
    mem_ready <= 1'b1;
    fault <= f;
    repeat (8) begin
      @(negedge clk);
      if (mem_wr !== 1'b0 || trap_take !== 1'b0 || cpu_halted !== 1'b1) c++;
      @(posedge clk);
      fault <= '0;
    end
    check(32'(c), 32'h0);
  endtask : hrun

  ////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #2000000;
    err_total++;
    finish_test;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({29'h0, cpu_halted, irq, mem_wr}, 32'h0);
    rd(trap_pkg::ctrl_off, 32'hF, 32'h0);
    rd(trap_pkg::irq_mask_off, 32'hF, 32'h0);
    wr(trap_pkg::ctrl_off, 32'h2);
    // table of ordinary cases with traps enabled
    for (int i = 0; i < 26; i++) begin
      r = rows[i];
      @(posedge clk);
      op_class <= r[24:21];
      op_valid <= (r[24:21] != 4'h0);
      {privileged, legacy_status_word} <= r[20:19];
      {ext_blocked, high_irq_active} <= r[18:17];
      ctx <= {r[16], r[16]};
      fault <= r[15:5];
      @(negedge clk);
      check(32'(trap_take), 32'(r[4]));
      @(posedge clk);
      op_valid <= 1'b0;
      fault <= '0;
      @(negedge clk);
      if (r[4]) check({28'h0, trap_code}, {28'h0, r[3:0]});
      repeat (3) @(posedge clk);
    end
    check({31'h0, cpu_halted}, 32'h0);
    // context store with stalled memory
    @(posedge clk);
    {privileged, legacy_status_word, ext_blocked, high_irq_active} <= 4'h8;
    ctx <= '0;
    mem_ready <= 1'b0;
    fault <= 11'h045;
    @(posedge clk);
    fault <= '0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mem_wr !== 1'b1 && n < 10);
    check({8'h0, mem_addr}, {8'h0, ctx_block_addr + 24'h10});
    check(mem_wdata, 32'h00000506);
    check(cpu_status_word, 32'h00000506);
    repeat (3) @(negedge clk);
    check({31'h0, mem_wr}, 32'h1);
    @(posedge clk);
    mem_ready <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({31'h0, mem_wr}, 32'h0);
    // blocked watchdog: 128 retires pass, the next one trips
    wr(trap_pkg::ctrl_off, 32'h6);
    t0 = takes;
    @(posedge clk);
    ext_blocked <= 1'b1;
    instr_retire <= 1'b1;
    repeat (128) @(posedge clk);
    instr_retire <= 1'b0;
    @(negedge clk);
    check(32'(takes - t0), 32'h0);
    @(posedge clk);
    instr_retire <= 1'b1;
    @(posedge clk);
    instr_retire <= 1'b0;
    repeat (3) @(negedge clk);
    check(32'(takes - t0), 32'h1);
    check({28'h0, trap_code}, 32'hB);
    rd(trap_pkg::irq_stat_off, 32'h4, 32'h4);
    @(posedge clk);
    ext_blocked <= 1'b0;
    // halts with traps disabled, plus registers and interrupt
    wr(trap_pkg::ctrl_off, 32'h0);
    hrun(1'b0, 11'h400, 5);
    rd(trap_pkg::irq_stat_off, 32'h2, 32'h2);
    wr(trap_pkg::status_off, 32'h0);
    rd(trap_pkg::status_off, 32'h3, 32'h3);
    rd(4'h2, 32'hFFFFFFFF, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(trap_pkg::irq_mask_off, 32'h2);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    wr(trap_pkg::irq_stat_off, 32'h2);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    rd(trap_pkg::irq_stat_off, 32'h2, 32'h0);
    wr(trap_pkg::ctrl_off, 32'h1);
    repeat (3) @(negedge clk);
    check({30'h0, cpu_halted, irq_active_light}, 32'h0);
    hrun(1'b1, 11'h400, 4);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({30'h0, cpu_halted, mem_wr}, 32'h0);
    hrun(1'b1, 11'h100, 4);
    wr(trap_pkg::ctrl_off, 32'h1);
    // traps that never halt, traps disabled
    @(posedge clk);
    legacy_status_word <= 1'b0;
    ctx <= '0;
    fault <= 11'h020;
    @(posedge clk);
    fault <= 11'h010;
    @(posedge clk);
    fault <= '0;
    repeat (4) @(negedge clk);
    check({31'h0, cpu_halted}, 32'h0);
    finish_test;
  end
endmodule : test_trap_halt_and_watchdog_control
